/* hdl/mcc_consts.svh */
// Constants of the memory cycle control block
`ifndef MCC_CONSTS_SVH
`define MCC_CONSTS_SVH

// Vector byte addresses of the reset and load traps
`define MCC_RST_WP_ADDR 16'h0000
`define MCC_RST_PC_ADDR 16'h0002
`define MCC_NMI_WP_ADDR 16'hFFFC
`define MCC_NMI_PC_ADDR 16'hFFFE

// Status value set by the reset trap
`define MCC_STATUS_CLEAR 16'h0000

// Core clock period and core clocks per processor clock half
`define MCC_CLK_PERIOD_NS 8
`define MCC_HALF_CYCLES 1

`endif

/* hdl/mcc_pkg.sv */
// Types of the memory cycle control block
package mcc_pkg;

    // Memory bus cycle states
    typedef enum logic [1:0] {
        MCC_BUS_IDLE = 2'b00,
        MCC_BUS_ADDR = 2'b01,
        MCC_BUS_WAIT = 2'b10,
        MCC_BUS_DATA = 2'b11
    } mcc_bus_state_t;

    // Trap vector fetch states
    typedef enum logic [1:0] {
        MCC_TRAP_NONE = 2'b00,
        MCC_TRAP_WP = 2'b01,
        MCC_TRAP_PC = 2'b10
    } mcc_trap_state_t;

endpackage

/* hdl/mcc_phase_gen.sv */
// Processor clock edge ticks derived from the core clock
`timescale 1ns/1ps
`include "mcc_consts.svh"
module mcc_phase_gen #(
    parameter int HALF_CYCLES = `MCC_HALF_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset_n,
    output logic rise_tick,
    output logic fall_tick
);
    import mcc_pkg::*;

    localparam int CNT_W = (HALF_CYCLES > 1) ? $clog2(HALF_CYCLES) : 1;

    // Refuse a half period shorter than one core clock
    if (HALF_CYCLES < 1) begin : g_bad_half
        $error("mcc_phase_gen: HALF_CYCLES must be at least 1");
    end

    logic [CNT_W-1:0] cnt_reg;
    logic high_reg;
    logic half_end;

    // A half ends on the last core clock of the count
    assign half_end = (cnt_reg == CNT_W'(HALF_CYCLES - 1));
    assign rise_tick = half_end & ~high_reg;
    assign fall_tick = half_end & high_reg;

    // Half period counter and level of the processor clock
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_reg <= '0;
            high_reg <= 1'b0;
        end else if (half_end) begin
            cnt_reg <= '0;
            high_reg <= ~high_reg;
        end else begin
            cnt_reg <= cnt_reg + CNT_W'(1);
        end
    end

endmodule // mcc_phase_gen

/* hdl/mcc_cycle_ctrl.sv */
// Memory bus cycle sequencer with reset and load trap entry
//
// Contract
// - Not ready in a memory cycle enters a wait and holds progress.
// - Wait flag stays high for the whole memory wait state.
// - Fetch flag high in instruction fetch cycles, low in all others.
// - Cycle end low announces a new machine cycle at next rise.
// - Load trap loads workspace and counter from FFFC and FFFE.
// - Load trap starts only once the current instruction completes.
// - Load trap input also ends an idle state.
// - Load trap held during reset is taken after the reset trap.
// - During reset, write strobe and serial strobe stay inactive.
// - Reset release runs trap from 0000 and 0002, then first fetch.
// - Reset trap clears every status bit.
// - Memory enable goes low with a valid address.
// - Read raises input direction with the address; write strobe high.
// - Fetch flag rises with memory enable in a fetch read.
// - Read end drops memory enable and input direction together.
// - Bus leaves input direction at read end, together with memory enable.
// - Write strobe low at first fall after enable; direction stays low.
// - Write end drops write strobe and memory enable together.
// - Ready sampled at first rise after enable; low means wait.
// - First rise with ready high ends the wait; cycle completes.
// - Serial strobe pulses to mark serial data.
`timescale 1ns/1ps
`include "mcc_consts.svh"
module mcc_cycle_ctrl #(
    parameter int HALF_CYCLES = `MCC_HALF_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic ready,
    input wire logic nonmaskable_trap_n,
    input wire logic [15:0] data_in,
    output logic [15:0] data_out,
    output logic data_oe,
    output logic [14:0] address_lines,
    output logic memory_enable_n,
    output logic data_bus_input_dir,
    output logic write_strobe_n,
    output logic instruction_fetch_flag,
    output logic machine_cycle_end_n,
    output logic wait_state_flag,
    output logic serial_io_strobe,
    output logic serial_data_out,
    input wire logic core_req_valid,
    input wire logic core_req_write,
    input wire logic core_req_fetch,
    input wire logic [14:0] core_req_addr,
    input wire logic [15:0] core_req_wdata,
    output logic core_req_ready,
    output logic core_rsp_valid,
    output logic [15:0] core_rsp_data,
    output logic core_stall,
    input wire logic core_insn_boundary,
    input wire logic core_idle,
    input wire logic core_cru_valid,
    input wire logic [14:0] core_cru_addr,
    input wire logic core_cru_bit,
    output logic core_cru_ready,
    input wire logic core_status_load,
    input wire logic [15:0] core_status_in,
    output logic [15:0] status_reg,
    output logic [15:0] workspace_pointer,
    output logic [15:0] program_counter,
    output logic trap_active,
    output logic trap_done
);
    import mcc_pkg::*;

    // ------------------------------------------------
    // Processor clock edges
    // ------------------------------------------------

    logic rise_tick;
    logic fall_tick;

    // Edge ticks of the processor clock
    mcc_phase_gen #(
        .HALF_CYCLES(HALF_CYCLES)
    ) u_phase (
        .core_clk(core_clk),
        .reset_n(reset_n),
        .rise_tick(rise_tick),
        .fall_tick(fall_tick)
    );

    // ------------------------------------------------
    // State
    // ------------------------------------------------

    mcc_bus_state_t bus_reg;
    mcc_bus_state_t bus_next;
    mcc_trap_state_t trap_reg;
    mcc_trap_state_t trap_next;
    logic [14:0] addr_reg;
    logic [15:0] wdata_reg;
    logic write_reg;
    logic fetch_reg;
    logic src_trap_reg;
    logic we_armed_reg;
    logic nmi_base_reg;
    logic reset_pend_reg;
    logic nmi_pend_reg;
    logic [1:0] cru_reg;
    logic cru_bit_reg;
    logic rsp_valid_reg;
    logic [15:0] rsp_data_reg;
    logic [15:0] wp_reg;
    logic [15:0] pc_reg;
    logic [15:0] st_reg;
    logic done_reg;

    // ------------------------------------------------
    // Arbitration of bus and traps
    // ------------------------------------------------

    logic bus_idle;
    logic bus_busy;
    logic trap_none;
    logic core_free;
    logic nmi_ok;
    logic take_reset;
    logic take_nmi;
    logic trap_issue;
    logic core_issue;
    logic cru_issue;
    logic start;
    logic cycle_done;
    logic [15:0] vec_addr;

    // Idle bus and no trap or serial transfer under way
    assign bus_idle = (bus_reg == MCC_BUS_IDLE);
    assign bus_busy = ~bus_idle;
    assign trap_none = (trap_reg == MCC_TRAP_NONE);
    assign core_free = rise_tick & bus_idle & trap_none
                       & ~reset_pend_reg & (cru_reg == 2'b00);

    // Load trap waits for an instruction bound or idle
    assign nmi_ok = nmi_pend_reg & (core_insn_boundary | core_idle);
    assign take_reset = rise_tick & bus_idle & trap_none
                        & reset_pend_reg;
    assign take_nmi = core_free & nmi_ok;

    // Core work only when no trap wants the bus
    assign core_req_ready = core_free & ~nmi_ok;
    assign core_cru_ready = core_free & ~nmi_ok & ~core_req_valid;
    assign core_issue = core_req_valid & core_req_ready;
    assign cru_issue = core_cru_valid & core_cru_ready;

    // Vector fetches go out on their own rising edges
    assign trap_issue = rise_tick & bus_idle & ~trap_none;
    assign start = trap_issue | core_issue;
    assign cycle_done = rise_tick & (bus_reg == MCC_BUS_DATA);

    // Vector address from trap kind and step
    assign vec_addr = nmi_base_reg
        ? ((trap_reg == MCC_TRAP_WP) ? `MCC_NMI_WP_ADDR
                                     : `MCC_NMI_PC_ADDR)
        : ((trap_reg == MCC_TRAP_WP) ? `MCC_RST_WP_ADDR
                                     : `MCC_RST_PC_ADDR);

    // ------------------------------------------------
    // Bus cycle sequencer
    // ------------------------------------------------

    // Next bus state, moved only on processor rising edges
    always_comb begin
        bus_next = bus_reg;
        if (rise_tick) begin
            case (bus_reg)
                MCC_BUS_IDLE: begin
                    if (start) begin
                        bus_next = MCC_BUS_ADDR;
                    end
                end
                MCC_BUS_ADDR: begin
                    // First rise after enable samples ready
                    bus_next = ready ? MCC_BUS_DATA
                                     : MCC_BUS_WAIT;
                end
                MCC_BUS_WAIT: begin
                    // Every rise in a wait samples ready again
                    bus_next = ready ? MCC_BUS_DATA
                                     : MCC_BUS_WAIT;
                end
                MCC_BUS_DATA: begin
                    bus_next = MCC_BUS_IDLE;
                end
                default: begin
                    bus_next = MCC_BUS_IDLE;
                end
            endcase
        end
    end

    // Bus state register
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            bus_reg <= MCC_BUS_IDLE;
        end else begin
            bus_reg <= bus_next;
        end
    end

    // Address and cycle kind held steady through any wait
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            addr_reg <= 15'h0000;
            wdata_reg <= 16'h0000;
            write_reg <= 1'b0;
            fetch_reg <= 1'b0;
            src_trap_reg <= 1'b0;
        end else if (trap_issue) begin
            addr_reg <= vec_addr[15:1];
            write_reg <= 1'b0;
            fetch_reg <= 1'b0;
            src_trap_reg <= 1'b1;
        end else if (core_issue) begin
            addr_reg <= core_req_addr;
            wdata_reg <= core_req_wdata;
            write_reg <= core_req_write;
            fetch_reg <= core_req_fetch;
            src_trap_reg <= 1'b0;
        end else if (cru_issue) begin
            addr_reg <= core_cru_addr;
        end
    end

    // Write strobe armed at the first fall after enable
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            we_armed_reg <= 1'b0;
        end else if (cycle_done) begin
            we_armed_reg <= 1'b0;
        end else if (fall_tick & write_reg & bus_busy) begin
            we_armed_reg <= 1'b1;
        end
    end

    // ------------------------------------------------
    // Memory pins
    // ------------------------------------------------

    // Enable and address appear together for every cycle
    assign memory_enable_n = ~bus_busy;
    assign address_lines = addr_reg;
    // Reads only; dropped with the enable at cycle end
    assign data_bus_input_dir = bus_busy & ~write_reg;
    assign write_strobe_n = ~(bus_busy & write_reg & we_armed_reg);
    assign instruction_fetch_flag = bus_busy & fetch_reg;
    // Drive data only from a fall inside a write
    assign data_oe = we_armed_reg;
    assign data_out = wdata_reg;
    // Last clock of a cycle, or a clock with no memory cycle
    assign machine_cycle_end_n =
        ~((bus_reg == MCC_BUS_DATA) | bus_idle);
    assign wait_state_flag = (bus_reg == MCC_BUS_WAIT);
    assign core_stall = (bus_reg == MCC_BUS_WAIT);

    // ------------------------------------------------
    // Read answer to the core
    // ------------------------------------------------

    // Data taken at the rise that closes the cycle
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            rsp_valid_reg <= 1'b0;
            rsp_data_reg <= 16'h0000;
        end else begin
            rsp_valid_reg <= cycle_done & ~src_trap_reg;
            if (cycle_done & ~write_reg) begin
                rsp_data_reg <= data_in;
            end
        end
    end

    assign core_rsp_valid = rsp_valid_reg;
    assign core_rsp_data = rsp_data_reg;

    // ------------------------------------------------
    // Trap sequencer
    // ------------------------------------------------

    // Workspace vector first, then counter vector
    always_comb begin
        trap_next = trap_reg;
        case (trap_reg)
            MCC_TRAP_NONE: begin
                if (take_reset | take_nmi) begin
                    trap_next = MCC_TRAP_WP;
                end
            end
            MCC_TRAP_WP: begin
                if (cycle_done & src_trap_reg) begin
                    trap_next = MCC_TRAP_PC;
                end
            end
            MCC_TRAP_PC: begin
                if (cycle_done & src_trap_reg) begin
                    trap_next = MCC_TRAP_NONE;
                end
            end
            default: begin
                trap_next = MCC_TRAP_NONE;
            end
        endcase
    end

    // Trap state and kind of vector pair
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            trap_reg <= MCC_TRAP_NONE;
            nmi_base_reg <= 1'b0;
        end else begin
            trap_reg <= trap_next;
            if (trap_none & (take_reset | take_nmi)) begin
                nmi_base_reg <= ~reset_pend_reg;
            end
        end
    end

    // Reset trap owed from release; load request kept until taken
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reset_pend_reg <= 1'b1;
            nmi_pend_reg <= 1'b0;
        end else begin
            if (take_reset) begin
                reset_pend_reg <= 1'b0;
            end
            // A low input wins over the clear of a taken trap
            if (!nonmaskable_trap_n) begin
                nmi_pend_reg <= 1'b1;
            end else if (take_nmi) begin
                nmi_pend_reg <= 1'b0;
            end
        end
    end

    // Vectors loaded as their reads close
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wp_reg <= 16'h0000;
            pc_reg <= 16'h0000;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (cycle_done & src_trap_reg) begin
                if (trap_reg == MCC_TRAP_WP) begin
                    wp_reg <= data_in;
                end else begin
                    pc_reg <= data_in;
                    done_reg <= 1'b1;
                end
            end
        end
    end

    // Status cleared on reset trap entry, else loaded by the core
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            st_reg <= `MCC_STATUS_CLEAR;
        end else if (take_reset) begin
            st_reg <= `MCC_STATUS_CLEAR;
        end else if (core_status_load) begin
            st_reg <= core_status_in;
        end
    end

    assign workspace_pointer = wp_reg;
    assign program_counter = pc_reg;
    assign status_reg = st_reg;
    assign trap_active = ~trap_none | reset_pend_reg;
    assign trap_done = done_reg;

    // ------------------------------------------------
    // Serial bit strobe
    // ------------------------------------------------

    // Address clock, then strobe clock, then back to idle
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cru_reg <= 2'b00;
            cru_bit_reg <= 1'b0;
        end else if (cru_issue) begin
            cru_reg <= 2'b01;
            cru_bit_reg <= core_cru_bit;
        end else if (rise_tick & (cru_reg != 2'b00)) begin
            cru_reg <= (cru_reg == 2'b01) ? 2'b10 : 2'b00;
        end
    end

    // High for the whole second processor clock
    assign serial_io_strobe = (cru_reg == 2'b10);
    assign serial_data_out = cru_bit_reg;

endmodule // mcc_cycle_ctrl

/* tb/mcc_mem_model.sv */
// Memory system model answering the block's bus cycles
`timescale 1ns/1ps
module mcc_mem_model (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic memory_enable_n,
    input wire logic data_bus_input_dir,
    input wire logic write_strobe_n,
    input wire logic [14:0] address_lines,
    input wire logic [15:0] data_out,
    input wire logic [3:0] wait_cycles,
    output logic ready,
    output logic [15:0] data_in
);
    logic [15:0] mem [int];
    int cnt_reg;
    logic tog_reg;
    // Stored word, a fixed pattern until written
    function automatic logic [15:0] word_at(input logic [14:0] a);
        return mem.exists(a) ? mem[a] : ({1'b0, a} ^ 16'h5A5A);
    endfunction
    // Cycle age and write capture
    always @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_reg <= 0;
            tog_reg <= 1'b0;
        end else begin
            cnt_reg <= memory_enable_n ? 0 : cnt_reg + 1;
            tog_reg <= ~tog_reg;
            if (!write_strobe_n && !memory_enable_n)
                mem[address_lines] = data_out;
        end
    end
    // Ready once the set latency has run out
    assign ready = (cnt_reg >= int'(wait_cycles));
    // A released bus shows a pattern that toggles every cycle
    assign data_in = data_bus_input_dir ? word_at(address_lines)
                                        : {16{tog_reg}} ^ 16'hC33C;
endmodule // mcc_mem_model

/* tb/mcc_monitor.sv */
// Assertion checker for the memory cycle control block
`timescale 1ns/1ps
module mcc_monitor #(
    parameter int HALF_CYCLES = 1
) (
    input wire logic core_clk,
    input wire logic reset_n,
    input wire logic ready,
    input wire logic [14:0] address_lines,
    input wire logic memory_enable_n,
    input wire logic data_bus_input_dir,
    input wire logic data_oe,
    input wire logic write_strobe_n,
    input wire logic instruction_fetch_flag,
    input wire logic machine_cycle_end_n,
    input wire logic wait_state_flag,
    input wire logic serial_io_strobe
);
    localparam int SMP = 2 * HALF_CYCLES - 1;
    localparam int WE1 = HALF_CYCLES;
    // ----------------------------------------
    // Bus cycle relations
    // ----------------------------------------
    AST_READ_END: assert property (@(posedge core_clk)
        disable iff (!reset_n) $rose(memory_enable_n) && $past(data_bus_input_dir)
        |-> !data_bus_input_dir && !data_oe) else $error("read end wrong");
    AST_WE_FIRST: assert property (@(posedge core_clk)
        disable iff (!reset_n) $fell(memory_enable_n) && !data_bus_input_dir
        |-> write_strobe_n ##[WE1:WE1] !write_strobe_n) else $error("late we");
    AST_WE_END: assert property (@(posedge core_clk)
        disable iff (!reset_n) $rose(write_strobe_n) |-> memory_enable_n)
        else $error("write strobe ended alone");
    AST_HOLD: assert property (@(posedge core_clk)
        disable iff (!reset_n) !memory_enable_n && !$past(memory_enable_n)
        |-> $stable(address_lines) && $stable(data_bus_input_dir))
        else $error("bus changed in cycle");
    AST_FETCH: assert property (@(posedge core_clk)
        disable iff (!reset_n) instruction_fetch_flag
        |-> !memory_enable_n && data_bus_input_dir) else $error("stray fetch");
    AST_WAIT_EN: assert property (@(posedge core_clk)
        disable iff (!reset_n) wait_state_flag
        |-> !memory_enable_n && machine_cycle_end_n) else $error("bad wait");
    AST_READY_LOW: assert property (@(posedge core_clk)
        disable iff (!reset_n) $fell(memory_enable_n) ##[SMP:SMP] !ready
        |-> ##1 wait_state_flag) else $error("no wait entered");
    AST_READY_HIGH: assert property (@(posedge core_clk)
        disable iff (!reset_n) $fell(memory_enable_n) ##[SMP:SMP] ready
        |-> ##1 !wait_state_flag && !machine_cycle_end_n)
        else $error("cycle not ending");
    AST_WAIT_END: assert property (@(posedge core_clk)
        disable iff (!reset_n) wait_state_flag && ready
        |-> ##[1:2] !wait_state_flag) else $error("wait did not end");
    AST_SERIAL: assert property (@(posedge core_clk)
        disable iff (!reset_n) $rose(serial_io_strobe)
        |-> ##1 serial_io_strobe ##1 !serial_io_strobe) else $error("strobe");
    AST_RESET_QUIET: assert property (@(posedge core_clk)
        !reset_n |-> write_strobe_n && !serial_io_strobe)
        else $error("strobe active in reset");
    // Main scenarios
    cover property (@(posedge core_clk) !write_strobe_n && wait_state_flag);
    cover property (@(posedge core_clk) instruction_fetch_flag);
    cover property (@(posedge core_clk) serial_io_strobe);
endmodule // mcc_monitor

bind mcc_cycle_ctrl mcc_monitor #(.HALF_CYCLES(HALF_CYCLES)) u_mon (
    .core_clk, .reset_n, .ready, .address_lines, .memory_enable_n,
    .data_bus_input_dir, .data_oe, .write_strobe_n, .instruction_fetch_flag,
    .machine_cycle_end_n, .wait_state_flag, .serial_io_strobe);

/* tb/tb_top.sv */
// Self-checking bench for the memory cycle control block
`timescale 1ns/1ps
module tb_top;
    logic core_clk, reset_n, ready, nonmaskable_trap_n, data_oe, men_q;
    logic [15:0] data_in, data_out, core_req_wdata, core_rsp_data;
    logic [15:0] core_status_in, status_reg, workspace_pointer, program_counter;
    logic [14:0] address_lines, core_req_addr, core_cru_addr, cru_a;
    logic memory_enable_n, data_bus_input_dir, write_strobe_n, cru_d;
    logic instruction_fetch_flag, machine_cycle_end_n, wait_state_flag;
    logic serial_io_strobe, serial_data_out, core_req_valid, core_req_write;
    logic core_req_fetch, core_req_ready, core_rsp_valid, core_stall;
    logic core_insn_boundary, core_idle, core_cru_valid, core_cru_bit;
    logic core_cru_ready, core_status_load, trap_active, trap_done;
    logic [3:0] wait_cycles;
    logic [16:0] bus_q [$];
    logic [15:0] mdl [int];
    int num_errors, n_checks, seed, cyc, waits, strobes, i;

    mcc_cycle_ctrl #(.HALF_CYCLES(1)) u_dut (
        .core_clk, .reset_n, .ready, .nonmaskable_trap_n, .data_in,
        .data_out, .data_oe, .address_lines, .memory_enable_n,
        .data_bus_input_dir, .write_strobe_n, .instruction_fetch_flag,
        .machine_cycle_end_n, .wait_state_flag, .serial_io_strobe,
        .serial_data_out, .core_req_valid, .core_req_write, .core_req_fetch,
        .core_req_addr, .core_req_wdata, .core_req_ready, .core_rsp_valid,
        .core_rsp_data, .core_stall, .core_insn_boundary, .core_idle,
        .core_cru_valid, .core_cru_addr, .core_cru_bit, .core_cru_ready,
        .core_status_load, .core_status_in, .status_reg, .workspace_pointer,
        .program_counter, .trap_active, .trap_done);

    mcc_mem_model u_mem (
        .core_clk, .reset_n, .memory_enable_n, .data_bus_input_dir,
        .write_strobe_n, .address_lines, .data_out, .wait_cycles, .ready,
        .data_in);

    // Clock at 125 MHz
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end

    // Bus watcher and time limit
    always @(negedge core_clk) begin
        cyc++;
        if (men_q && !memory_enable_n)
            bus_q.push_back({~data_bus_input_dir, instruction_fetch_flag,
                             address_lines});
        waits += wait_state_flag + core_stall;
        if (serial_io_strobe) begin
            strobes++;
            cru_a = address_lines;
            cru_d = serial_data_out;
        end
        men_q = memory_enable_n;
        if (cyc == 6000) begin
            num_errors++;
            stop_test();
        end
    end

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic stop_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic wait_flag(ref logic f);
        for (int k = 0; k < 300 && f !== 1'b1; k++) @(negedge core_clk);
    endtask

    function automatic logic [15:0] exp_word(input logic [14:0] a);
        return mdl.exists(a) ? mdl[a] : ({1'b0, a} ^ 16'h5A5A);
    endfunction

    // Wait clocks: ready seen at the first rise after latency
    function automatic int exp_waits(input int w);
        int r;
        r = (w < 1) ? 2 : w + 1;
        if (r % 2) r++;
        return r - 2;
    endfunction

    task automatic expect_cycle(input logic [16:0] e);
        for (int k = 0; k < 300 && bus_q.size() == 0; k++) @(negedge core_clk);
        check(bus_q.size() ? bus_q.pop_front() : ~e, e);
    endtask

    task automatic expect_trap(input logic [14:0] wa);
        expect_cycle({2'b00, wa});
        expect_cycle({2'b00, wa + 15'h0001});
        wait_flag(trap_done);
        check(trap_active, 1'b0);
        check(workspace_pointer, exp_word(wa));
        check(program_counter, exp_word(wa + 15'h0001));
    endtask

    task automatic access(input logic wr, fe, input logic [14:0] a,
                          input logic [15:0] d, input int w);
        wait_cycles = w[3:0];
        core_req_valid = 1'b1;
        core_req_write = wr;
        core_req_fetch = fe;
        core_req_addr = a;
        core_req_wdata = d;
        waits = 0;
        #1;
        wait_flag(core_req_ready);
        @(negedge core_clk);
        core_req_valid = 1'b0;
        wait_flag(core_rsp_valid);
        expect_cycle({wr, fe, a});
        check(waits, 2 * exp_waits(w));
        if (wr) mdl[a] = d;
        else check(core_rsp_data, exp_word(a));
    endtask

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        seed = 32'h6403;
        {reset_n, core_req_valid, core_req_write, core_req_fetch} = 4'h0;
        {core_insn_boundary, core_idle, core_cru_valid, core_cru_bit} = 4'h0;
        {core_req_addr, core_cru_addr, core_req_wdata} = 46'h0;
        {core_status_load, core_status_in, wait_cycles} = 21'h0;
        nonmaskable_trap_n = 1'b1;
        men_q = 1'b1;
        repeat (20) @(negedge core_clk);
        reset_n = 1'b1;
        expect_trap(15'h0000);
        check(status_reg, 16'h0000);
        // Random writes with read-back, fetch and wait mix
        for (i = 0; i < 30; i++) begin
            core_req_addr = $random(seed);
            access(1'b1, 1'b0, core_req_addr, $random(seed), i % 5);
            access(1'b0, i[0], core_req_addr, 16'h0000, (i + 2) % 5);
        end
        // Serial strobe with both bit values
        for (i = 0; i < 2; i++) begin
            strobes = 0;
            core_cru_addr = $random(seed);
            core_cru_bit = i[0];
            core_cru_valid = 1'b1;
            #1;
            wait_flag(core_cru_ready);
            @(negedge core_clk);
            core_cru_valid = 1'b0;
            repeat (8) @(negedge core_clk);
            check(strobes, 2);
            check({cru_a, cru_d}, {core_cru_addr, core_cru_bit});
        end
        // Status value to be cleared later
        core_status_in = $random(seed);
        core_status_load = 1'b1;
        @(negedge core_clk);
        core_status_load = 1'b0;
        // Load request waits for an instruction boundary
        nonmaskable_trap_n = 1'b0;
        repeat (4) @(negedge core_clk);
        nonmaskable_trap_n = 1'b1;
        repeat (20) @(negedge core_clk);
        check(bus_q.size(), 0);
        core_insn_boundary = 1'b1;
        expect_trap(15'h7FFE);
        core_insn_boundary = 1'b0;
        // Load request ends an idle state
        nonmaskable_trap_n = 1'b0;
        repeat (2) @(negedge core_clk);
        nonmaskable_trap_n = 1'b1;
        core_idle = 1'b1;
        expect_trap(15'h7FFE);
        core_idle = 1'b0;
        // Second reset with the load request held through it
        nonmaskable_trap_n = 1'b0;
        core_insn_boundary = 1'b1;
        reset_n = 1'b0;
        repeat (20) @(negedge core_clk);
        bus_q.delete();
        reset_n = 1'b1;
        repeat (2) @(negedge core_clk);
        nonmaskable_trap_n = 1'b1;
        expect_trap(15'h0000);
        check(status_reg, 16'h0000);
        expect_trap(15'h7FFE);
        core_insn_boundary = 1'b0;
        access(1'b0, 1'b1, 15'h7FFF, 16'h0000, 3);
        stop_test();
    end
endmodule // tb_top
